// *** bench/block_ram_reset_sequencer_test.sv ***
// Self-checking bench for the memory and its reset handling.
module block_ram_reset_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;

	// Stimulus and observed signals.
	logic clk, rst, global_reset_enable, sync_reset, fifo_reset, read_pointer_reset, req;
	logic global_set_reset, en_gate, fifo_full, fifo_empty;
	block_mem_pkg::mem_mode_t mode;
	block_mem_pkg::cfg_load_t cfg;
	block_mem_pkg::user_wr_t wr_q, wr_port;
	block_mem_pkg::user_rd_t rd_q, rd_port;
	logic [block_mem_pkg::DATA_W-1:0] rd_data;
	logic [block_mem_pkg::PTR_W-1:0] fifo_level;
	int num_errors = 0;
	int samples_checked = 0;

	// The user sequencer gates every enable while its reset runs.
	assign wr_port = '{wr_q.ce & en_gate, wr_q.en & en_gate, wr_q.addr, wr_q.data};
	assign rd_port = '{rd_q.ce & en_gate, rd_q.en & en_gate, rd_q.addr};

	user_reset_driver u_user_reset_driver (.clk(clk), .rst(rst), .req(req),
		.global_set_reset(global_set_reset), .en_gate(en_gate));
	block_ram_reset_sequencer u_block_ram_reset_sequencer (.clk(clk), .rst(rst),
		.mode(mode), .global_reset_enable(global_reset_enable), .cfg(cfg),
		.global_set_reset(global_set_reset),
		.sync_reset(sync_reset), .fifo_reset(fifo_reset),
		.read_pointer_reset(read_pointer_reset), .wr_port(wr_port), .rd_port(rd_port),
		.rd_data(rd_data), .fifo_full(fifo_full), .fifo_empty(fifo_empty),
		.fifo_level(fifo_level));

	// Free-running clock, 8 ns period.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Compares one value and counts it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
			num_errors++;
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("Mismatches %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Sets a mode and restarts the block, since the mode is static.
	task automatic restart(input block_mem_pkg::mem_mode_t m, input logic g);
		@(posedge clk);
		mode <= m;
		global_reset_enable <= g;
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
	endtask

	// Writes one word, reads it back and compares with the expected word.
	task automatic access(input logic [8:0] a, input logic [17:0] d, input logic [17:0] e);
		@(posedge clk);
		wr_q <= '{1'b1, 1'b1, a, d};
		@(posedge clk);
		wr_q <= '0;
		rd_q <= '{1'b1, 1'b1, a};
		@(posedge clk);
		rd_q <= '0;
		@(negedge clk);
		check(rd_data, e);
	endtask

	// Runs one sequenced global reset; returns while it is high.
	task automatic pulse_global();
		@(posedge clk);
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		@(posedge global_set_reset);
		#1;
	endtask

	// RAM: read back, asynchronous global reset, disabled global reset, sync reset.
	task automatic test_ram();
		restart(block_mem_pkg::MODE_RAM, 1'b1);
		access(9'h005, 18'h1_2345, 18'h1_2345);
		pulse_global();
		check(rd_data, 18'h0_0000);
		restart(block_mem_pkg::MODE_RAM, 1'b0);
		access(9'h1FF, 18'h2_ABCD, 18'h2_ABCD);
		pulse_global();
		repeat (3) @(negedge clk);
		check(rd_data, 18'h2_ABCD);
		@(posedge clk);
		sync_reset <= 1'b1;
		@(posedge clk);
		sync_reset <= 1'b0;
		@(negedge clk);
		check(rd_data, 18'h0_0000);
	endtask

	// ROM: preloaded word survives a user write attempt.
	task automatic test_rom();
		restart(block_mem_pkg::MODE_ROM, 1'b0);
		@(posedge clk);
		cfg <= '{1'b1, 1'b1, 9'h00A, 18'h3_C0DE};
		@(posedge clk);
		cfg <= '0;
		access(9'h00A, 18'h0_1111, 18'h3_C0DE);
	endtask

	// FIFO: pointer resets act at once; global reset stays on when disabled.
	task automatic test_fifo();
		restart(block_mem_pkg::MODE_FIFO, 1'b0);
		@(posedge clk);
		wr_q <= '{1'b0, 1'b1, 9'h000, 18'h0_00A1};
		@(posedge clk);
		wr_q <= '{1'b0, 1'b1, 9'h000, 18'h0_00A2};
		@(posedge clk);
		wr_q <= '0;
		rd_q <= '{1'b0, 1'b1, 9'h000};
		@(posedge clk);
		rd_q <= '0;
		@(negedge clk);
		check(rd_data, 18'h0_00A1);
		check(fifo_level, 10'h001);
		@(posedge clk);
		read_pointer_reset <= 1'b1;
		#1;
		check(fifo_level, 10'h002);
		@(posedge clk);
		read_pointer_reset <= 1'b0;
		fifo_reset <= 1'b1;
		#1;
		check(fifo_empty, 1'b1);
		@(posedge clk);
		fifo_reset <= 1'b0;
		@(posedge clk);
		wr_q <= '{1'b0, 1'b1, 9'h000, 18'h0_00A3};
		@(posedge clk);
		wr_q <= '0;
		pulse_global();
		check(fifo_level, 10'h000);
		// Wait out the guard cycle, then push one word more than fits.
		repeat (2) @(posedge clk);
		wr_q <= '{1'b0, 1'b1, 9'h000, 18'h0_00B0};
		repeat (513) @(posedge clk);
		wr_q <= '0;
		@(negedge clk);
		check(fifo_full, 1'b1);
		check(fifo_empty, 1'b0);
		check(fifo_level, 10'h200);
	endtask

	// Main sequence.
	initial begin
		rst = 1'b1;
		mode = block_mem_pkg::MODE_RAM;
		global_reset_enable = 1'b0;
		cfg = '0;
		sync_reset = 1'b0;
		fifo_reset = 1'b0;
		read_pointer_reset = 1'b0;
		req = 1'b0;
		wr_q = '0;
		rd_q = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		test_ram();
		test_rom();
		test_fifo();
		results();
	end

	// Cuts a hang short well past the expected few hundred cycles.
	initial begin
		repeat (2000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule // block_ram_reset_sequencer_test

// *** bench/user_reset_driver.sv ***
// User-side logic that gates the memory enables around each global reset.
module user_reset_driver (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// One-cycle pulse that asks for one global reset.
	input wire logic req,
	// Reset to the memory and gate for its enables.
	output logic global_set_reset,
	output logic en_gate
);
	timeunit 1ns;
	timeprecision 1ps;

	// Phase: 0 idle, 1 guard before, 2 reset, 3 guard after.
	logic [1:0] phase_ff;

	// A request that comes while a sequence runs is not held, so it is lost; only one seen in idle starts a reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_ff <= 2'h0;
		end else if (phase_ff != 2'h0 || req) begin
			phase_ff <= phase_ff + 2'h1;
		end
	end

	// Enables stay low one full cycle on each side of the reset pulse.
	assign en_gate = (phase_ff == 2'h0);
	// Decoded from the phase flop just after an edge of the one steady clock.
	assign global_set_reset = (phase_ff == 2'h2);
endmodule // user_reset_driver

// *** rtl/block_mem_array.sv ***
module block_mem_array (
	// Clock.
	input wire logic clk,
	// Write request.
	input wire block_mem_pkg::mem_wr_t wr,
	// Read address and the word stored there.
	input wire logic [block_mem_pkg::ADDR_W-1:0] rd_addr,
	output logic [block_mem_pkg::DATA_W-1:0] rd_word
);

	// Storage words; contents are never cleared by any reset.
	logic [block_mem_pkg::DATA_W-1:0] mem_ff [2**block_mem_pkg::ADDR_W];

	// Writes land on the clock edge.
	always_ff @(posedge clk) begin
		if (wr.en) begin
			mem_ff[wr.addr] <= wr.data;
		end
	end

	// The read is a plain lookup; the caller registers it.
	assign rd_word = mem_ff[rd_addr];

endmodule // block_mem_array

// *** rtl/block_mem_pkg.sv ***
package block_mem_pkg;

	// Address width of one block: 512 words.
	localparam int ADDR_W = 9;

	// Data width of one word.
	localparam int DATA_W = 18;

	// Pointer width in FIFO mode: one extra bit tells full from empty.
	localparam int PTR_W = ADDR_W + 1;

	// Value taken by the output data register on any reset.
	localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;

	// Value taken by the FIFO pointers on any reset.
	localparam logic [PTR_W-1:0] PTR_RST = 10'h000;

	// Pointer difference that marks a full FIFO: wrap bit set, address bits equal.
	localparam logic [PTR_W-1:0] PTR_FULL_DIFF = 10'h200;

	// One pointer step.
	localparam logic [PTR_W-1:0] PTR_STEP = 10'h001;

	// Operating configuration of the block, fixed while it runs.
	typedef enum logic [1:0] {
		MODE_RAM = 2'b00,
		MODE_ROM = 2'b01,
		MODE_FIFO = 2'b10
	} mem_mode_t;

	// One write into the storage array.
	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mem_wr_t;

	// User write port: clock enable, write enable, address and data.
	typedef struct packed {
		logic ce;
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} user_wr_t;

	// User read port: clock enable, read enable and address.
	typedef struct packed {
		logic ce;
		logic en;
		logic [ADDR_W-1:0] addr;
	} user_rd_t;

	// Preload port used while the device is being configured.
	typedef struct packed {
		logic active;
		logic load;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cfg_load_t;

endpackage

// *** rtl/block_ram_reset_sequencer.sv ***
module block_ram_reset_sequencer (
	// Clock and block reset.
	input wire logic clk,
	input wire logic rst,
	// Configuration: mode, global reset enable and preload port.
	input wire block_mem_pkg::mem_mode_t mode,
	input wire logic global_reset_enable,
	input wire block_mem_pkg::cfg_load_t cfg,
	// Resets from user logic.
	input wire logic global_set_reset,
	input wire logic sync_reset,
	input wire logic fifo_reset,
	input wire logic read_pointer_reset,
	// User write and read ports.
	input wire block_mem_pkg::user_wr_t wr_port,
	input wire block_mem_pkg::user_rd_t rd_port,
	// Read data and FIFO status.
	output logic [block_mem_pkg::DATA_W-1:0] rd_data,
	output logic fifo_full,
	output logic fifo_empty,
	output logic [block_mem_pkg::PTR_W-1:0] fifo_level
);

	// Advances a FIFO pointer by one place, wrap bit included.
	function automatic logic [block_mem_pkg::PTR_W-1:0] ptr_next(
		input logic [block_mem_pkg::PTR_W-1:0] ptr);
		ptr_next = ptr + block_mem_pkg::PTR_STEP;
	endfunction

	// Mode decodes.
	wire is_fifo = (mode == block_mem_pkg::MODE_FIFO);
	wire is_ram = (mode == block_mem_pkg::MODE_RAM);

	// The global reset reaches the block when enabled, and always in FIFO mode.
	wire global_reset_live = global_set_reset & (global_reset_enable | is_fifo);

	// Asynchronous clears, widest first; none waits for a clock edge.
	wire clr_all = rst | global_reset_live;
	wire clr_fifo = clr_all | (is_fifo & fifo_reset);
	wire clr_rptr = clr_fifo | (is_fifo & read_pointer_reset);

	// FIFO pointers and their next values.
	logic [block_mem_pkg::PTR_W-1:0] wptr_ff;
	logic [block_mem_pkg::PTR_W-1:0] rptr_ff;
	logic [block_mem_pkg::PTR_W-1:0] nxt_wptr;
	logic [block_mem_pkg::PTR_W-1:0] nxt_rptr;

	// Output data register and its next value.
	logic [block_mem_pkg::DATA_W-1:0] rd_data_ff;
	logic [block_mem_pkg::DATA_W-1:0] nxt_rd_data;

	// Word looked up in the array.
	logic [block_mem_pkg::DATA_W-1:0] array_word;

	// FIFO status from the pointers.
	wire [block_mem_pkg::PTR_W-1:0] ptr_diff = wptr_ff - rptr_ff;
	wire full_w = (ptr_diff == block_mem_pkg::PTR_FULL_DIFF);
	wire empty_w = (ptr_diff == block_mem_pkg::PTR_RST);

	// User traffic is shut out while the device is being configured.
	wire user_on = ~cfg.active;

	// In FIFO mode the write and read enables do the work of clock enables.
	wire fifo_push = user_on & is_fifo & wr_port.en & ~full_w;
	wire fifo_pop = user_on & is_fifo & rd_port.en & ~empty_w;

	// Random-access writes need both enables; read-only mode has no write path.
	wire ram_write = user_on & is_ram & wr_port.ce & wr_port.en;

	// Read-only and random-access reads are taken on the read clock enable.
	wire array_read = user_on & ~is_fifo & rd_port.ce;

	// Write into the array: preload during configuration, else user traffic.
	block_mem_pkg::mem_wr_t arr_wr;
	assign arr_wr.en = (cfg.active & cfg.load) | ram_write | fifo_push;
	assign arr_wr.addr = cfg.active ? cfg.addr :
		(is_fifo ? wptr_ff[block_mem_pkg::ADDR_W-1:0] : wr_port.addr);
	assign arr_wr.data = cfg.active ? cfg.data : wr_port.data;

	// Read address: the read pointer in FIFO mode, else the user address.
	wire [block_mem_pkg::ADDR_W-1:0] arr_rd_addr =
		is_fifo ? rptr_ff[block_mem_pkg::ADDR_W-1:0] : rd_port.addr;

	// Storage array.
	block_mem_array u_array (
		.clk(clk),
		.wr(arr_wr),
		.rd_addr(arr_rd_addr),
		.rd_word(array_word)
	);

	// Pointer steps.
	assign nxt_wptr = fifo_push ? ptr_next(wptr_ff) : wptr_ff;
	assign nxt_rptr = fifo_pop ? ptr_next(rptr_ff) : rptr_ff;

	// Synchronous reset clears the output regardless of any enable.
	assign nxt_rd_data = sync_reset ? block_mem_pkg::DATA_RST :
		((array_read | fifo_pop) ? array_word : rd_data_ff);

	// Write pointer: cleared by the full FIFO reset at once.
	always_ff @(posedge clk or posedge clr_fifo) begin
		if (clr_fifo) begin
			wptr_ff <= block_mem_pkg::PTR_RST;
		end else begin
			wptr_ff <= nxt_wptr;
		end
	end

	// Read pointer: also cleared alone by the read-pointer reset.
	always_ff @(posedge clk or posedge clr_rptr) begin
		if (clr_rptr) begin
			rptr_ff <= block_mem_pkg::PTR_RST;
		end else begin
			rptr_ff <= nxt_rptr;
		end
	end

	// Output register: cleared at once by the global reset when enabled, and always in FIFO mode.
	always_ff @(posedge clk or posedge clr_all) begin
		if (clr_all) begin
			rd_data_ff <= block_mem_pkg::DATA_RST;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	// Outputs.
	assign rd_data = rd_data_ff;
	assign fifo_full = full_w;
	assign fifo_empty = empty_w;
	assign fifo_level = ptr_diff;

	// Checks run on the one clock and stand down during block reset.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// A live global reset keeps the output cleared, with no edge needed.
	// A one-cycle pulse is enough, so no earlier sample is asked for.
	chk_global_clears_output: assert property (
		global_reset_live |-> rd_data == block_mem_pkg::DATA_RST)
		else $error("Output not cleared under global reset.");

	// In FIFO mode the global reset empties the FIFO even when disabled.
	chk_fifo_global_forced: assert property (
		is_fifo && !global_reset_enable && global_set_reset
		|-> fifo_empty && fifo_level == block_mem_pkg::PTR_RST)
		else $error("FIFO global reset did not take effect.");

	// A FIFO without write enable keeps its write side still.
	// An asynchronous clear in between may move it, so that case stands aside.
	chk_fifo_we_gates: assert property (
		is_fifo && !wr_port.en && !clr_fifo && !cfg.active ##1 !clr_fifo
		|-> $stable(wptr_ff))
		else $error("FIFO write pointer moved without write enable.");

	// A FIFO without read enable keeps its read side still.
	chk_fifo_re_gates: assert property (
		is_fifo && !rd_port.en && !clr_rptr && !cfg.active ##1 !clr_rptr
		|-> $stable(rptr_ff))
		else $error("FIFO read pointer moved without read enable.");

	// A read on an empty FIFO is refused and the output holds.
	chk_empty_read_holds: assert property (
		is_fifo && fifo_empty && !sync_reset && !clr_all ##1 !clr_all
		|-> $stable(rd_data))
		else $error("Output changed on a read of an empty FIFO.");

	// The FIFO never holds more than one block of words.
	chk_level_bound: assert property (
		is_fifo |-> fifo_level <= block_mem_pkg::PTR_FULL_DIFF)
		else $error("FIFO level passed the full mark.");

	// A full reset empties the FIFO at once, without an edge.
	chk_full_reset_empty: assert property (
		is_fifo && fifo_reset |-> fifo_empty && !fifo_full)
		else $error("Full FIFO reset did not empty the FIFO.");

	// A read-pointer reset clears only the read side, at once.
	chk_rptr_reset_only: assert property (
		is_fifo && read_pointer_reset && !clr_fifo
		|-> rptr_ff == block_mem_pkg::PTR_RST && fifo_level == wptr_ff)
		else $error("Read-pointer reset misbehaved.");

	// A disabled global reset leaves the output of an idle RAM or ROM block alone.
	chk_global_off_holds: assert property (
		!is_fifo && !global_reset_enable && global_set_reset && !array_read && !sync_reset
		|=> $stable(rd_data))
		else $error("Disabled global reset changed the output.");

	// The synchronous reset clears the output on the next edge, enables aside.
	chk_sync_reset_free: assert property (
		sync_reset && !clr_all |=> rd_data == block_mem_pkg::DATA_RST)
		else $error("Synchronous reset did not clear the output.");

	// Outside configuration a read-only block never writes its array.
	chk_rom_no_write: assert property (
		mode == block_mem_pkg::MODE_ROM && !cfg.active |-> !arr_wr.en)
		else $error("Read-only block wrote its array.");

	// A read in any mode shows up on the output one edge later.
	chk_read_lands: assert property (
		(array_read || fifo_pop) && !sync_reset && !clr_all ##1 !clr_all
		|-> rd_data == $past(array_word))
		else $error("Read data did not land on the output.");

	// Main scenarios.
	cov_fifo_full: cover property (is_fifo && fifo_full);
	cov_rptr_reset_busy: cover property (is_fifo && read_pointer_reset && !fifo_empty);
	cov_rom_read: cover property (mode == block_mem_pkg::MODE_ROM && array_read);
	cov_sync_reset: cover property (sync_reset && rd_data != block_mem_pkg::DATA_RST);
	cov_global_off: cover property (is_ram && global_set_reset && !global_reset_enable);

endmodule // block_ram_reset_sequencer
